/* core/irqfe_pkg.sv */
// constants shared by the interrupt request front end
// assumes a single pclk domain and an APB register port
`default_nettype none

package irqfe_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MASK = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_STATE = 8'h0C;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int unsigned CTL_W = 7;
  localparam int unsigned CTL_EDGE_LSB = 0;
  localparam int unsigned CTL_ACK0 = 4;
  localparam int unsigned CTL_ACK1 = 5;
  localparam int unsigned CTL_SLAVE = 6;
  localparam logic [6:0] CTRL_RST = 7'h00;

  // ----------------------------------------------------------------
  // event / mask / state fields
  // ----------------------------------------------------------------
  localparam int unsigned EV_W = 5;
  localparam int unsigned EV_NMI = 0;
  localparam int unsigned EV_REQ_LSB = 1;
  localparam logic [4:0] MASK_RST = 5'h00;
  localparam int unsigned ST_PEND_LSB = 0;
  localparam int unsigned ST_LVL_LSB = 4;
  localparam int unsigned ST_NMI_BIT = 8;

  // ----------------------------------------------------------------
  // service and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] NMI_TYPE = 8'h02;
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    IRQFE_IDLE = 2'b00,
    IRQFE_HELD = 2'b01,
    IRQFE_TAKE = 2'b11
  } irqfe_nmi_st_t;

endpackage

`default_nettype wire

/* core/irqfe_line_if.sv */
// one synchronised request line: level and rising-edge pulse
// assumes both ends sit in the pclk domain
`default_nettype none

interface irqfe_line_if;
  logic level;
  logic rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface

`default_nettype wire

/* core/irqfe_sync.sv */
// synchroniser with rising-edge detection for one request pin
// assumes pclk and asynchronous active-low presetn
`default_nettype none

module irqfe_sync #(
  parameter int unsigned STAGES = irqfe_pkg::SYNC_STAGES
) (
  input wire logic pclk,       // system clock
  input wire logic presetn,    // async reset, active low
  input wire logic din,        // raw pin level
  irqfe_line_if.src line       // synchronised level and edge
);

  logic [STAGES-1:0] sync_r;
  logic past_r;

  // the first stage feeds only the next stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_r <= '0;
      past_r <= 1'b0;
    end else begin
      sync_r <= {sync_r[STAGES-2:0], din};
      past_r <= sync_r[STAGES-1];
    end
  end

  assign line.level = sync_r[STAGES-1];
  assign line.rise = sync_r[STAGES-1] & ~past_r;

endmodule

`default_nettype wire

/* core/irqfe_top.sv */
// interrupt request front end: nmi capture, four maskable request pins,
// edge/level trigger select, active-low acknowledge outputs, slave mode
// assumes one pclk domain, APB access, core gives instruction boundaries
//
// Our own choices: the address map and the APB interface to the registers.
`default_nettype none

module irqfe_top (
  input wire logic pclk,                // system clock
  input wire logic presetn,             // async reset, active low
  input wire logic psel,                // apb select
  input wire logic penable,             // apb enable
  input wire logic pwrite,              // apb direction
  input wire logic [7:0] paddr,         // apb byte address
  input wire logic [31:0] pwdata,       // apb write data
  output logic [31:0] prdata,           // apb read data
  output logic pready,                  // apb ready
  output logic pslverr,                 // apb error
  input wire logic nmi_in,              // non-maskable request pin
  input wire logic mask_req_zero,       // request pin 0
  input wire logic mask_req_one,        // request pin 1
  input wire logic mask_req_two_in,     // pin 2 input side
  output logic mask_req_two_out,        // pin 2 output (ack_out_zero)
  output logic mask_req_two_oe_n,       // pin 2 enable, low drives
  input wire logic mask_req_three_in,   // pin 3 input side
  output logic mask_req_three_out,      // pin 3 output (ack_out_one)
  output logic mask_req_three_oe_n,     // pin 3 enable, low drives
  input wire logic instr_boundary,      // core at instruction boundary
  input wire logic [3:0] ack_strobe,    // core acknowledges request n
  output logic nmi_service,             // pulse: nmi taken
  output logic [7:0] service_type,      // interrupt type of last nmi
  output logic [3:0] req_active,        // requests offered to the core
  output logic irq                      // status interrupt, level
);

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  irqfe_line_if nmi_line ();
  irqfe_line_if req_line [4] ();
  logic [3:0] pin_raw;
  logic [3:0] lvl;
  logic [3:0] rise;

  assign pin_raw = {mask_req_three_in, mask_req_two_in, mask_req_one, mask_req_zero};

  irqfe_sync #(.STAGES(irqfe_pkg::SYNC_STAGES)) u_nmi_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(nmi_in),
    .line(nmi_line)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_req
      irqfe_sync #(.STAGES(irqfe_pkg::SYNC_STAGES)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din(pin_raw[gi]),
        .line(req_line[gi])
      );
      assign lvl[gi] = req_line[gi].level;
      assign rise[gi] = req_line[gi].rise;
    end
  endgenerate

  // ----------------------------------------------------------------
  // registers and decode
  // ----------------------------------------------------------------
  logic [irqfe_pkg::CTL_W-1:0] ctrl_r;
  logic [irqfe_pkg::EV_W-1:0] mask_r;
  logic [irqfe_pkg::EV_W-1:0] status_r;
  logic [irqfe_pkg::EV_W-1:0] status_nxt;
  logic [3:0] pend_r;
  logic [3:0] pend_nxt;
  logic nmi_latch_r;
  irqfe_pkg::irqfe_nmi_st_t nmi_st_r;
  irqfe_pkg::irqfe_nmi_st_t nmi_st_nxt;
  logic [7:0] type_r;
  logic two_out_r;
  logic two_oe_n_r;
  logic three_out_r;
  logic three_oe_n_r;
  logic [31:0] rdata_r;

  wire acc = psel & penable;
  wire hit_ctrl = paddr == irqfe_pkg::OFF_CTRL;
  wire hit_mask = paddr == irqfe_pkg::OFF_MASK;
  wire hit_status = paddr == irqfe_pkg::OFF_STATUS;
  wire hit_state = paddr == irqfe_pkg::OFF_STATE;
  wire mapped = hit_ctrl | hit_mask | hit_status | hit_state;
  wire wr_ctrl = acc & pwrite & hit_ctrl;
  wire wr_mask = acc & pwrite & hit_mask;
  wire rd_status = acc & ~pwrite & hit_status;

  wire [3:0] edge_mode = ctrl_r[irqfe_pkg::CTL_EDGE_LSB +: 4];
  wire slave = ctrl_r[irqfe_pkg::CTL_SLAVE];
  // acknowledge roles exist only outside slave mode
  wire ack0_mode = ctrl_r[irqfe_pkg::CTL_ACK0] & ~slave;
  wire ack1_mode = ctrl_r[irqfe_pkg::CTL_ACK1] & ~slave;

  // in slave mode pin 0 is the only request; pin 3 carries the request
  // out to the cascade master, pins 1 and 2 are not evaluated
  wire [3:0] pin_is_req = slave ? 4'h1 : {~ack1_mode, ~ack0_mode, 2'h3};

  // ----------------------------------------------------------------
  // maskable requests
  // ----------------------------------------------------------------
  // edge pending: set on synced rise, held until the core acks; set wins
  assign pend_nxt = (pend_r & ~ack_strobe) | (rise & edge_mode & pin_is_req);

  // level mode follows the synchronised pin, high is active
  wire [3:0] lvl_req = lvl & ~edge_mode & pin_is_req;
  wire [3:0] req_nxt = (pend_r & edge_mode & pin_is_req) | lvl_req;

  // ----------------------------------------------------------------
  // nmi sequencing
  // ----------------------------------------------------------------
  wire nmi_take = nmi_st_r == irqfe_pkg::IRQFE_HELD && instr_boundary;

  always_comb begin
    nmi_st_nxt = nmi_st_r;
    case (nmi_st_r)
      irqfe_pkg::IRQFE_IDLE: begin
        if (nmi_latch_r) begin
          nmi_st_nxt = irqfe_pkg::IRQFE_HELD;
        end
      end
      irqfe_pkg::IRQFE_HELD: begin
        if (instr_boundary) begin
          nmi_st_nxt = irqfe_pkg::IRQFE_TAKE;
        end
      end
      irqfe_pkg::IRQFE_TAKE: begin
        nmi_st_nxt = irqfe_pkg::IRQFE_IDLE;
      end
      default: begin
        nmi_st_nxt = irqfe_pkg::IRQFE_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // status events: a read clears only what it returned, a new event wins
  // ----------------------------------------------------------------
  wire [irqfe_pkg::EV_W-1:0] ev = {rise & pin_is_req, nmi_line.rise};
  // rdata_r holds the setup-cycle snapshot, so an event between setup and access survives
  wire [irqfe_pkg::EV_W-1:0] rd_clr = rd_status ? rdata_r[irqfe_pkg::EV_W-1:0] : '0;
  assign status_nxt = (status_r & ~rd_clr) | ev;

  wire [31:0] state_word = {23'h000000, nmi_latch_r, lvl, pend_r};

  wire [31:0] rd_mux =
    hit_ctrl ? {25'h0000000, ctrl_r} :
    hit_mask ? {27'h0000000, mask_r} :
    hit_status ? {27'h0000000, status_r} :
    hit_state ? state_word : 32'h00000000;

  // ----------------------------------------------------------------
  // flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= irqfe_pkg::CTRL_RST;
      mask_r <= irqfe_pkg::MASK_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= pwdata[irqfe_pkg::CTL_W-1:0];
      end
      if (wr_mask) begin
        mask_r <= pwdata[irqfe_pkg::EV_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
      pend_r <= '0;
      req_active <= '0;
      rdata_r <= '0;
    end else begin
      status_r <= status_nxt;
      pend_r <= pend_nxt;
      req_active <= req_nxt;
      rdata_r <= (psel & ~penable & ~pwrite) ? rd_mux : rdata_r;
    end
  end

  // nmi latch has no enable from software at all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_latch_r <= 1'b0;
      nmi_st_r <= irqfe_pkg::IRQFE_IDLE;
      type_r <= '0;
    end else begin
      nmi_latch_r <= (nmi_latch_r & ~nmi_take) | nmi_line.rise;
      nmi_st_r <= nmi_st_nxt;
      type_r <= nmi_take ? irqfe_pkg::NMI_TYPE : type_r;
    end
  end

  // acknowledge outputs pulse low for the cycle after the core's ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      two_out_r <= 1'b1;
      two_oe_n_r <= 1'b1;
      three_out_r <= 1'b1;
      three_oe_n_r <= 1'b1;
    end else begin
      two_out_r <= ~(ack0_mode & ack_strobe[2]);
      two_oe_n_r <= ~ack0_mode;
      three_out_r <= slave ? lvl[0] | pend_r[0] : ~(ack1_mode & ack_strobe[3]);
      three_oe_n_r <= ~(ack1_mode | slave);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = rdata_r;
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign nmi_service = nmi_st_r == irqfe_pkg::IRQFE_TAKE;
  assign service_type = type_r;
  assign irq = |(status_r & mask_r);
  assign mask_req_two_out = two_out_r;
  assign mask_req_two_oe_n = two_oe_n_r;
  assign mask_req_three_out = three_out_r;
  assign mask_req_three_oe_n = three_oe_n_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_nmi_rise;
    nmi_line.rise;
  endsequence
  sequence s_nmi_wait;
    nmi_st_r == irqfe_pkg::IRQFE_HELD && instr_boundary;
  endsequence

  property p_nmi_type;
    nmi_service |-> service_type == irqfe_pkg::NMI_TYPE;
  endproperty
  a_nmi_type: assert property (p_nmi_type) else $error("nmi taken with wrong type");

  property p_nmi_latch;
    s_nmi_rise |=> nmi_latch_r;
  endproperty
  a_nmi_latch: assert property (p_nmi_latch) else $error("nmi rise not latched");

  property p_nmi_boundary;
    s_nmi_wait |=> nmi_service;
  endproperty
  a_nmi_boundary: assert property (p_nmi_boundary) else $error("nmi not taken at boundary");

  property p_nmi_only_boundary;
    $rose(nmi_service) |-> $past(instr_boundary);
  endproperty
  a_nmi_only_boundary: assert property (p_nmi_only_boundary) else $error("nmi taken off boundary");

  property p_nmi_unmaskable;
    s_nmi_rise ##0 (nmi_st_r == irqfe_pkg::IRQFE_IDLE && !nmi_latch_r)
      ##1 (instr_boundary [*2]) |=> nmi_service;
  endproperty
  a_nmi_unmaskable: assert property (p_nmi_unmaskable) else $error("nmi ignored");

  property p_level_high;
    (lvl[0] && !edge_mode[0]) |=> req_active[0];
  endproperty
  a_level_high: assert property (p_level_high) else $error("level request lost");

  property p_sync_delay;
    $rose(mask_req_zero) ##1 mask_req_zero [*2] |-> lvl[0];
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("pin 0 not synchronised in two");

  property p_ack_pulse;
    (ack0_mode && ack_strobe[2]) |=> !mask_req_two_out && !mask_req_two_oe_n;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack output not driven low");

  property p_edge_hold;
    (pend_r[1] && !ack_strobe[1]) |=> pend_r[1];
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("edge pending dropped early");

  property p_slave_pins;
    slave |-> req_nxt[3:1] == 3'h0 ##1 mask_req_two_oe_n;
  endproperty
  a_slave_pins: assert property (p_slave_pins) else $error("slave mode pins misused");

  property p_nmi_sync;
    $rose(nmi_in) |=> !nmi_line.rise ##1 nmi_line.rise;
  endproperty
  a_nmi_sync: assert property (p_nmi_sync) else $error("nmi edge not synchronised");

  property p_nmi_held;
    (nmi_latch_r && nmi_st_r == irqfe_pkg::IRQFE_IDLE) |=> nmi_st_r == irqfe_pkg::IRQFE_HELD;
  endproperty
  a_nmi_held: assert property (p_nmi_held) else $error("latched nmi not held for service");

  property p_nmi_status;
    s_nmi_rise |=> status_r[irqfe_pkg::EV_NMI];
  endproperty
  a_nmi_status: assert property (p_nmi_status) else $error("nmi event not recorded");

  property p_req_sync;
    $rose(mask_req_zero) |=> !lvl[0] ##1 lvl[0];
  endproperty
  a_req_sync: assert property (p_req_sync) else $error("pin 0 synchroniser depth wrong");

  property p_level_drop;
    (!lvl[0] && !edge_mode[0]) |=> !req_active[0];
  endproperty
  a_level_drop: assert property (p_level_drop) else $error("level request kept without pin");

  property p_edge_only;
    (edge_mode[1] && !pend_r[1] && !slave) |=> !req_active[1];
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("edge request offered without pending");

  property p_edge_set;
    (rise[1] && edge_mode[1] && !slave) |=> pend_r[1];
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge pending not set");

  property p_edge_clear;
    (ack_strobe[1] && !rise[1]) |=> !pend_r[1];
  endproperty
  a_edge_clear: assert property (p_edge_clear) else $error("edge pending not cleared by ack");

  property p_slave_out;
    (slave && (lvl[0] || pend_r[0])) |=> mask_req_three_out && !mask_req_three_oe_n;
  endproperty
  a_slave_out: assert property (p_slave_out) else $error("slave request out not driven");

  property p_ack_idle;
    (!ack1_mode && !slave) |=> mask_req_three_oe_n && mask_req_three_out;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("pin 3 driven outside ack mode");

endmodule

`default_nettype wire

/* test/irqfe_partner.sv */
// external requesters: nmi source and four request pins, plus pin 2/3 wire resolution
// assumes bench gives one-cycle go strobes in the pclk domain
`default_nettype none

module irqfe_partner (
  input wire logic pclk,        // system clock
  input wire logic presetn,     // async reset, active low
  input wire logic nmi_go,      // start an nmi assertion
  input wire logic [3:0] req_go, // start a request on pin n
  input wire logic pulse_mode,  // drop requests early, before ack
  input wire logic [3:0] ack_strobe, // acknowledges seen from core
  input wire logic two_out,     // pin 2 device output
  input wire logic two_oe_n,    // pin 2 enable, low drives
  input wire logic three_out,   // pin 3 device output
  input wire logic three_oe_n,  // pin 3 enable, low drives
  output logic nmi_in,          // nmi pin
  output logic req0,            // pin 0
  output logic req1,            // pin 1
  output logic two_in,          // pin 2 wire level
  output logic three_in         // pin 3 wire level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] hold_r;
  logic [1:0] nmi_cnt_r;
  logic [1:0] age_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r <= 4'h0;
      nmi_cnt_r <= 2'h0;
      age_r <= 2'h0;
    end else begin
      // three cycles of nmi, above the one-cycle minimum
      if (nmi_go) nmi_cnt_r <= 2'h3;
      else if (nmi_cnt_r != 2'h0) nmi_cnt_r <= nmi_cnt_r - 2'h1;
      age_r <= (|req_go) ? 2'h0 : age_r + {1'b0, age_r != 2'h3};
      for (int n = 0; n < 4; n++) begin
        if (req_go[n]) hold_r[n] <= 1'b1;
        else if (ack_strobe[n] || (pulse_mode && age_r == 2'h3)) hold_r[n] <= 1'b0;
      end
    end
  end

  assign nmi_in = nmi_cnt_r != 2'h0;
  assign req0 = hold_r[0];
  assign req1 = hold_r[1];
  // a pin driven by the device shows the device's level on the wire
  assign two_in = two_oe_n ? hold_r[2] : two_out;
  assign three_in = three_oe_n ? hold_r[3] : three_out;
endmodule

`default_nettype wire

/* test/irqfe_bench.sv */
// self-checking bench for the interrupt request front end
// assumes the irqfe design files and the partner model are compiled first
`default_nettype none

module irqfe_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr, service_type;
  logic [31:0] pwdata, prdata, rd;
  logic nmi_in, rq0, rq1, two_in, two_out, two_oe_n, three_in, three_out, three_oe_n;
  logic instr_boundary, nmi_service, nmi_go, pulse_mode, err;
  logic [3:0] ack_strobe, req_active, req_go;
  int n_mismatch, checks, seen;

  irqfe_top i_irqfe_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .nmi_in(nmi_in),
    .mask_req_zero(rq0), .mask_req_one(rq1), .mask_req_two_in(two_in), .mask_req_two_out(two_out),
    .mask_req_two_oe_n(two_oe_n), .mask_req_three_in(three_in), .mask_req_three_out(three_out),
    .mask_req_three_oe_n(three_oe_n), .instr_boundary(instr_boundary), .ack_strobe(ack_strobe),
    .nmi_service(nmi_service), .service_type(service_type), .req_active(req_active), .irq(irq));
  irqfe_partner i_irqfe_partner (.pclk(pclk), .presetn(presetn), .nmi_go(nmi_go), .req_go(req_go),
    .pulse_mode(pulse_mode), .ack_strobe(ack_strobe), .two_out(two_out), .two_oe_n(two_oe_n),
    .three_out(three_out), .three_oe_n(three_oe_n), .nmi_in(nmi_in), .req0(rq0), .req1(rq1),
    .two_in(two_in), .three_in(three_in));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready is tied high, so this wait ends after one cycle
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic strobe_ack(input int n);
    @(posedge pclk);
    ack_strobe[n] <= 1'b1;
    @(posedge pclk);
    ack_strobe <= 4'h0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, irqfe_pkg::OFF_CTRL, 32'h0);
    chk("ctrl", rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped rd", rd, 32'h0);
    chk("ready", {31'h0, pready}, 32'h1);
    chk("oe", {30'h0, two_oe_n, three_oe_n}, 32'h3);
  endtask

  task automatic t_nmi();
    instr_boundary <= 1'b0;
    @(posedge pclk);
    nmi_go <= 1'b1;
    @(posedge pclk);
    nmi_go <= 1'b0;
    cyc(10);
    chk("nmi early", {31'h0, nmi_service}, 32'h0);
    apb(1'b0, irqfe_pkg::OFF_STATE, 32'h0);
    chk("nmi latch", {31'h0, rd[8]}, 32'h1);
    instr_boundary <= 1'b1;
    seen = 0;
    repeat (8) begin
      @(negedge pclk);
      seen += int'(nmi_service === 1'b1);
    end
    chk("nmi taken", seen, 32'h1);
    chk("type", {24'h0, service_type}, 32'h2);
    // second nmi while boundaries keep coming: taken with no setup at all
    @(posedge pclk);
    nmi_go <= 1'b1;
    @(posedge pclk);
    nmi_go <= 1'b0;
    seen = 0;
    repeat (8) begin
      @(negedge pclk);
      seen += int'(nmi_service === 1'b1);
    end
    @(posedge pclk);
    instr_boundary <= 1'b0;
    chk("nmi again", seen, 32'h1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, irqfe_pkg::OFF_MASK, 32'h1);
    cyc(2);
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1'b0, irqfe_pkg::OFF_STATUS, 32'h0);
    chk("status", rd, 32'h1);
    cyc(2);
    chk("irq clr", {31'h0, irq}, 32'h0);
  endtask

  task automatic t_level();
    @(posedge pclk);
    req_go <= 4'h1;
    @(posedge pclk);
    req_go <= 4'h0;
    @(negedge pclk);
    chk("sync delay", {28'h0, req_active}, 32'h0);
    cyc(6);
    chk("level act", {28'h0, req_active}, 32'h1);
    strobe_ack(0);
    cyc(6);
    chk("level drop", {28'h0, req_active}, 32'h0);
  endtask

  task automatic t_edge();
    apb(1'b1, irqfe_pkg::OFF_CTRL, 32'h2);
    pulse_mode <= 1'b1;
    @(posedge pclk);
    req_go <= 4'h2;
    @(posedge pclk);
    req_go <= 4'h0;
    cyc(12);
    chk("pin gone", {31'h0, rq1}, 32'h0);
    apb(1'b0, irqfe_pkg::OFF_STATE, 32'h0);
    chk("pending", {28'h0, rd[3:0]}, 32'h2);
    chk("edge act", {28'h0, req_active}, 32'h2);
    strobe_ack(1);
    pulse_mode <= 1'b0;
    cyc(3);
    apb(1'b0, irqfe_pkg::OFF_STATE, 32'h0);
    chk("pend clr", {28'h0, rd[3:0]}, 32'h0);
  endtask

  task automatic t_ack();
    apb(1'b1, irqfe_pkg::OFF_CTRL, 32'h30);
    cyc(3);
    chk("ack oe", {30'h0, two_oe_n, three_oe_n}, 32'h0);
    for (int k = 2; k < 4; k++) begin
      strobe_ack(k);
      seen = 0;
      repeat (4) begin
        @(negedge pclk);
        seen += int'((k == 2 ? two_out : three_out) === 1'b0);
      end
      chk("ack low", seen, 32'h1);
    end
  endtask

  task automatic t_slave();
    apb(1'b1, irqfe_pkg::OFF_CTRL, 32'h40);
    @(posedge pclk);
    req_go <= 4'h2;
    @(posedge pclk);
    req_go <= 4'h1;
    @(posedge pclk);
    req_go <= 4'h0;
    cyc(8);
    chk("slave act", {28'h0, req_active}, 32'h1);
    chk("slave out", {30'h0, three_oe_n, three_out}, 32'h1);
  endtask

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    #(4000 * 50);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    n_mismatch = 0;
    checks = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, nmi_go, pulse_mode, instr_boundary} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    ack_strobe = 4'h0;
    req_go = 4'h0;
    cyc(6);
    presetn <= 1'b1;
    t_reset();
    t_nmi();
    t_level();
    t_edge();
    t_ack();
    t_slave();
    report_and_stop();
  end
endmodule

`default_nettype wire
